/* File: hw/scir_top.sv */
// serial shift clock, frame sequencer and interrupt with ahb-lite regs
// assumes one ahb-lite master, zero-wait slave, hclk as source clock
`timescale 1ns/1ps

// How it works
// - shift clock is source clock divided by 2, 4, 8 or 16
// - source clock comes from resonator or external clock, then divided
// - interrupt enable 1 raises interrupt output when a frame ends and the irq mask bit is 1
// - a word read of the rx or control register drops a raised interrupt output
// - interrupt enable 0 stops frame ends from raising interrupt output
// - under reset output enable, shift clock and data output sit high
// - reset clears busy, sets ack, disables interrupt, selects 1/2
// - control bits 1:0 pick 1/2, 1/4, 1/8, 1/16
// - frame ends one bit after 16th rise; outputs high, busy clear
// - status read returns enable, busy, ack and ratio
module scir_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        serial_data_in,
    output logic             serial_clk,
    output logic             serial_data_out,
    output logic             serial_oe_n,
    output logic             int_out
);
    scir_div_if dv ();

    scir_pkg::scir_state_type state;
    logic                            take;
    logic                            take_word;
    logic [scir_pkg::IDX_W-1:0]      a_idx;
    logic                            dp_write;
    logic [scir_pkg::IDX_W-1:0]      dp_idx;
    logic                            wr_en;
    logic                            rd_access;
    logic [31:0]                     next_rdata;
    logic                            int_en;
    logic [scir_pkg::RATIO_W-1:0]    ratio;
    logic [7:0]                      tx_high;
    logic [scir_pkg::TX_W-1:0]       shreg;
    logic [scir_pkg::RX_W-1:0]       rx;
    logic [7:0]                      rx_data;
    logic                            ack;
    logic [4:0]                      rise_cnt;
    logic [4:0]                      next_rise;
    logic [3:0]                      tail_cnt;
    logic [3:0]                      tail_m1;
    logic                            start;
    logic                            done;
    logic                            busy;
    logic                            int_pend;
    logic                            int_mask;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    // zero wait states: read data is registered in the address phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel && htrans[1] && hready;
    assign take_word = take && (hsize == scir_pkg::HSIZE_WORD);
    assign a_idx     = haddr[scir_pkg::ADDR_LSB +: scir_pkg::IDX_W];
    assign wr_en     = dp_write;
    assign rd_access = take_word && !hwrite &&
                       (a_idx == scir_pkg::IDX_RX ||
                        a_idx == scir_pkg::IDX_CTRL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_idx   <= 4'h0;
        end else begin
            dp_write <= take_word && hwrite;
            dp_idx   <= a_idx;
        end
    end

    // unmapped indexes read as zero and ignore writes
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (a_idx == scir_pkg::IDX_TX_HIGH) begin
            next_rdata[7:0] = tx_high;
        end else if (a_idx == scir_pkg::IDX_RX) begin
            next_rdata[7:0] = rx_data;
        end else if (a_idx == scir_pkg::IDX_CTRL) begin
            next_rdata[scir_pkg::CTRL_IE_BIT]   = int_en;
            next_rdata[scir_pkg::STAT_BUSY_BIT] = busy;
            next_rdata[scir_pkg::STAT_ACK_BIT]  = ack;
            next_rdata[scir_pkg::RATIO_W-1:0]   = ratio;
        end else if (a_idx == scir_pkg::IDX_IRQ_STAT) begin
            next_rdata[0] = int_pend;
        end else if (a_idx == scir_pkg::IDX_IRQ_MASK) begin
            next_rdata[0] = int_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take_word && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_en <= 1'b0;
            ratio  <= scir_pkg::RATIO_RST;
        end else if (wr_en && dp_idx == scir_pkg::IDX_CTRL) begin
            int_en <= hwdata[scir_pkg::CTRL_IE_BIT];
            ratio  <= hwdata[scir_pkg::RATIO_W-1:0];
        end
    end

    // transmit bytes are only taken while idle, so a frame never tears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_high <= 8'h00;
        end else if (wr_en && dp_idx == scir_pkg::IDX_TX_HIGH &&
                     state == scir_pkg::st_idle) begin
            tx_high <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    assign start     = wr_en && dp_idx == scir_pkg::IDX_TX_LOW &&
                       state == scir_pkg::st_idle;
    assign busy      = (state != scir_pkg::st_idle);
    assign next_rise = rise_cnt + 5'h01;
    // trailing bit lasts one full sclk period
    assign tail_m1   = 4'((5'h02 << ratio) - 5'h01);
    assign done      = (state == scir_pkg::st_tail) && (tail_cnt == tail_m1);
    assign dv.run    = (state == scir_pkg::st_shift);
    assign dv.ratio  = ratio;
    assign serial_clk = dv.sclk;

    scir_div u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .dv      (dv.gen)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= scir_pkg::st_idle;
            rise_cnt <= 5'h00;
            tail_cnt <= 4'h0;
        end else begin
            case (state)
                scir_pkg::st_idle: begin
                    rise_cnt <= 5'h00;
                    tail_cnt <= 4'h0;
                    if (start) begin
                        state <= scir_pkg::st_shift;
                    end
                end
                scir_pkg::st_shift: begin
                    if (dv.rise_tick) begin
                        rise_cnt <= next_rise;
                        if (next_rise == scir_pkg::LAST_RISE) begin
                            state <= scir_pkg::st_tail;
                        end
                    end
                end
                scir_pkg::st_tail: begin
                    tail_cnt <= tail_cnt + 4'h1;
                    if (done) begin
                        state <= scir_pkg::st_idle;
                    end
                end
                default: begin
                    state <= scir_pkg::st_idle;
                end
            endcase
        end
    end

    // data changes on falling sclk, msb of the high byte first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg           <= 16'h0000;
            serial_data_out <= 1'b1;
        end else if (start) begin
            shreg           <= {tx_high, hwdata[7:0]};
        end else if (dv.fall_tick) begin
            serial_data_out <= shreg[scir_pkg::TX_W-1];
            shreg           <= {shreg[scir_pkg::TX_W-2:0], 1'b0};
        end else if (done) begin
            serial_data_out <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_oe_n <= 1'b1;
        end else if (start) begin
            serial_oe_n <= 1'b0;
        end else if (done) begin
            serial_oe_n <= 1'b1;
        end
    end

    // rises 8..16 are captured: the first is the ack bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx      <= 9'h000;
            rx_data <= 8'h00;
            ack     <= scir_pkg::ACK_RST;
        end else if (state == scir_pkg::st_shift && dv.rise_tick &&
                     next_rise >= scir_pkg::ACK_RISE) begin
            rx      <= {rx[scir_pkg::RX_W-2:0], serial_data_in};
        end else if (done) begin
            ack     <= rx[scir_pkg::RX_W-1];
            rx_data <= rx[7:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // a frame end with interrupt enable 1 in the same cycle as a clear keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_pend <= 1'b0;
        end else if (done && int_en) begin
            int_pend <= 1'b1;
        end else if (rd_access) begin
            int_pend <= 1'b0;
        end else if (wr_en && dp_idx == scir_pkg::IDX_IRQ_STAT &&
                     hwdata[0]) begin
            int_pend <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask <= scir_pkg::MASK_RST;
        end else if (wr_en && dp_idx == scir_pkg::IDX_IRQ_MASK) begin
            int_mask <= hwdata[0];
        end
    end

    assign int_out = int_pend && int_mask;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_int_set;
        @(posedge hclk) disable iff (!hresetn)
        (done && int_en && int_mask &&
         !(wr_en && dp_idx == scir_pkg::IDX_IRQ_MASK)) |=> int_out;
    endproperty
    a_int_set: assert property (p_int_set)
        else $error("interrupt not raised at frame end");

    property p_int_off;
        @(posedge hclk) disable iff (!hresetn)
        (!int_en && !int_pend) |=> !int_out;
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("interrupt rose while disabled");

    property p_int_clr;
        @(posedge hclk) disable iff (!hresetn)
        (rd_access && !done) |=> !int_out;
    endproperty
    a_int_clr: assert property (p_int_clr)
        else $error("read did not clear interrupt");

    property p_write_keeps;
        @(posedge hclk) disable iff (!hresetn)
        (int_pend && take && hwrite && !done &&
         a_idx != scir_pkg::IDX_IRQ_STAT &&
         !(wr_en && dp_idx == scir_pkg::IDX_IRQ_STAT)) |=> int_pend;
    endproperty
    a_write_keeps: assert property (p_write_keeps)
        else $error("write access cleared interrupt");

    property p_idle_high;
        @(posedge hclk) disable iff (!hresetn)
        (state == scir_pkg::st_idle && !$past(start)) |->
            (serial_clk && serial_data_out && serial_oe_n);
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("serial pins not high while idle");

    property p_tail;
        @(posedge hclk) disable iff (!hresetn)
        (dv.rise_tick && next_rise == scir_pkg::LAST_RISE &&
         ratio == 2'h0) |=> busy ##1 busy ##1 (!busy && serial_oe_n);
    endproperty
    a_tail: assert property (p_tail)
        else $error("frame end not one bit after last rise");

    property p_fast_div;
        @(posedge hclk) disable iff (!hresetn)
        (dv.run && ratio == 2'h0 && $fell(serial_clk)) |=>
            serial_clk;
    endproperty
    a_fast_div: assert property (p_fast_div)
        else $error("sclk not divided by 2 at ratio 0");

    property p_ack;
        @(posedge hclk) disable iff (!hresetn)
        done |=> (ack == $past(rx[scir_pkg::RX_W-1]) && !busy);
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack bit not captured at frame end");

endmodule : scir_top

/* File: common/scir_pkg.sv */
// constants, register map and state type of the serial clock / irq block
// assumes a 32-bit ahb-lite slave with word-aligned registers
package scir_pkg;

    // ------------------------------------------------------------
    // register map: byte address = index * 4
    // ------------------------------------------------------------
    localparam int unsigned  ADDR_LSB      = 2;
    localparam int unsigned  IDX_W         = 4;
    localparam logic [3:0]   IDX_TX_LOW    = 4'h0;
    localparam logic [3:0]   IDX_TX_HIGH   = 4'h1;
    localparam logic [3:0]   IDX_RX        = 4'h2;
    localparam logic [3:0]   IDX_CTRL      = 4'h3;
    localparam logic [3:0]   IDX_IRQ_STAT  = 4'h4;
    localparam logic [3:0]   IDX_IRQ_MASK  = 4'h5;
    localparam logic [2:0]   HSIZE_WORD    = 3'h2;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned  CTRL_IE_BIT   = 7;
    localparam int unsigned  STAT_BUSY_BIT = 3;
    localparam int unsigned  STAT_ACK_BIT  = 2;
    localparam int unsigned  RATIO_W       = 2;
    localparam logic [1:0]   RATIO_RST     = 2'h0;
    localparam logic         ACK_RST       = 1'b1;
    localparam logic         MASK_RST      = 1'b1;

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    localparam logic [4:0]   ACK_RISE      = 5'h08;
    localparam logic [4:0]   LAST_RISE     = 5'h10;
    localparam int unsigned  RX_W          = 9;
    localparam int unsigned  TX_W          = 16;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_shift = 2'b01,
        st_tail  = 2'b10
    } scir_state_type;

endpackage : scir_pkg

/* File: common/scir_div_if.sv */
// link between the frame sequencer and the shift clock divider
// assumes both ends run on hclk
`timescale 1ns/1ps
interface scir_div_if;
    logic       run;
    logic [1:0] ratio;
    logic       sclk;
    logic       fall_tick;
    logic       rise_tick;

    modport ctl (output run, ratio, input sclk, fall_tick, rise_tick);
    modport gen (input run, ratio, output sclk, fall_tick, rise_tick);
endinterface : scir_div_if

/* File: hw/scir_div.sv */
// shift clock divider: sclk = hclk / 2^(ratio+1) while run is high
// assumes hclk is the oscillator or external source clock
`timescale 1ns/1ps
module scir_div (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    scir_div_if.gen     dv
);
    logic [2:0] cnt;
    logic [2:0] half_m1;
    logic       wrap;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // half period is 1, 2, 4 or 8 source cycles
    assign half_m1 = 3'((4'h1 << dv.ratio) - 4'h1);
    assign wrap    = dv.run && (cnt == half_m1);
    assign dv.fall_tick = wrap && dv.sclk;
    assign dv.rise_tick = wrap && !dv.sclk;

    // idle level is high, so a stopped divider parks sclk high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt     <= 3'h0;
            dv.sclk <= 1'b1;
        end else if (!dv.run) begin
            cnt     <= 3'h0;
            dv.sclk <= 1'b1;
        end else if (wrap) begin
            cnt     <= 3'h0;
            dv.sclk <= ~dv.sclk;
        end else begin
            cnt     <= cnt + 3'h1;
        end
    end

    property p_half_slow;
        @(posedge hclk) disable iff (!hresetn)
        (dv.run && dv.ratio == 2'h3 && $fell(dv.sclk)) |->
            (!dv.sclk || !dv.run) [*8];
    endproperty
    a_half_slow: assert property (p_half_slow)
        else $error("sclk low phase shorter than 8 cycles at 1/16");

endmodule : scir_div

/* File: tb/scir_periph.sv */
// serial bus peripheral on the far side of the shift link
// assumes the device launches data on sclk falls and samples on rises
`timescale 1ns/1ps
module scir_periph (
    input  wire logic        serial_clk,
    input  wire logic        serial_oe_n,
    input  wire logic        serial_data_out,
    input  wire logic [8:0]  reply,
    output logic             serial_data_in,
    output logic      [15:0] got
);
    int falls;

    initial begin
        serial_data_in = 1'b1;
        got = 16'h0000;
        falls = 0;
    end

    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    always @(negedge serial_oe_n) begin
        falls = 0;
    end

    // reply moves on falls so it is steady when the device samples a rise
    always @(negedge serial_clk) begin
        if (serial_oe_n === 1'b0) begin
            falls = falls + 1;
            if (falls >= 8 && falls <= 16)
                serial_data_in <= reply[16 - falls];
            else
                serial_data_in <= ~serial_data_in;
        end
    end

    always @(posedge serial_clk) begin
        if (serial_oe_n === 1'b0)
            got <= {got[14:0], serial_data_out};
    end

    // line released: never leave the last bit standing
    always @(posedge serial_oe_n) begin
        serial_data_in <= ~serial_data_in;
    end
endmodule : scir_periph

/* File: tb/serial_clock_irq_reset_tb.sv */
// self-checking bench for the shift clock, frame end and interrupt
// assumes scir_top as the only ahb-lite slave, scir_periph on the link
`timescale 1ns/1ps
module serial_clock_irq_reset_tb;
    typedef struct packed {
        logic [1:0]  ratio;
        logic        ie;
        logic [15:0] tx;
        logic [8:0]  rep;
    } scir_row_type;

    logic         hclk;
    logic         hresetn;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic         serial_data_in;
    logic         serial_clk;
    logic         serial_data_out;
    logic         serial_oe_n;
    logic         int_out;
    logic [8:0]   reply;
    logic [15:0]  got;
    logic [31:0]  d;
    int           err_count;
    int           n_compared;
    int           per;
    int           tail;
    scir_row_type rows [4];

    scir_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .serial_data_in(serial_data_in), .serial_clk(serial_clk),
        .serial_data_out(serial_data_out), .serial_oe_n(serial_oe_n),
        .int_out(int_out)
    );

    scir_periph periph_u (
        .serial_clk(serial_clk), .serial_oe_n(serial_oe_n),
        .serial_data_out(serial_data_out), .reply(reply),
        .serial_data_in(serial_data_in), .got(got)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask : chk

    // single word transfer from the next rising edge; read data lands in d
    task automatic ahb(input logic sel, input logic [3:0] idx,
                       input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= sel;
        haddr  <= {26'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= scir_pkg::HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask : ahb

    // cycles between first two falls, and from 16th rise to frame end
    task automatic watch(output int period, output int tail_n);
        int   c;
        int   f1;
        int   r16;
        int   falls;
        int   rises;
        logic prev;
        c = 0;
        f1 = 0;
        r16 = 0;
        falls = 0;
        rises = 0;
        period = 0;
        prev = 1'b1;
        do begin
            @(posedge hclk);
            #1;
            c++;
            if (prev && !serial_clk) begin
                falls++;
                if (falls == 1) f1 = c;
                if (falls == 2) period = c - f1;
            end
            if (!prev && serial_clk) begin
                rises++;
                if (rises == 16) r16 = c;
            end
            prev = serial_clk;
        end while (!(falls > 0 && serial_oe_n === 1'b1));
        tail_n = c - r16;
    endtask : watch

    // caller drives hresetn low first
    task automatic do_reset();
        repeat (2) @(posedge hclk);
        #1;
        chk("idle outs", 32'h7,
            {29'h0, serial_clk, serial_data_out, serial_oe_n});
        chk("irq in reset", 32'h0, {31'h0, int_out});
        chk("hresp okay", 32'h0, {31'h0, hresp});
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b0, 32'h0);
        chk("status after reset", 32'h4, d);
        ahb(1'b1, scir_pkg::IDX_IRQ_MASK, 1'b0, 32'h0);
        chk("mask after reset", 32'h1, d);
        $display("test reset done");
    endtask : do_reset

    task automatic run_row(input scir_row_type r);
        logic [31:0] h;
        h = 32'h2 << r.ratio;
        reply = r.rep;
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b1,
            {24'h0, r.ie, 5'h0, r.ratio});
        ahb(1'b1, scir_pkg::IDX_TX_HIGH, 1'b1, {24'h0, r.tx[15:8]});
        ahb(1'b1, scir_pkg::IDX_TX_LOW, 1'b1, {24'h0, r.tx[7:0]});
        watch(per, tail);
        chk("sclk period", h, per);
        chk("end delay", h, tail);
        chk("shifted word", {16'h0, r.tx}, {16'h0, got});
        chk("serial_data_out idle", 32'h1, {31'h0, serial_data_out});
        @(posedge hclk);
        #1;
        chk("irq at end", {31'h0, r.ie}, {31'h0, int_out});
        ahb(1'b1, scir_pkg::IDX_RX, 1'b0, 32'h0);
        chk("rx data", {24'h0, r.rep[7:0]}, d);
        #1;
        chk("irq after rx read", 32'h0, {31'h0, int_out});
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b0, 32'h0);
        chk("status", {24'h0, r.ie, 4'h0, r.rep[8], r.ratio}, d);
    endtask : run_row

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = scir_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        reply = 9'h000;
        err_count = 0;
        n_compared = 0;
        rows[0] = '{2'h0, 1'b1, 16'hA5C3, 9'h0B4};
        rows[1] = '{2'h1, 1'b0, 16'h8001, 9'h1FF};
        rows[2] = '{2'h2, 1'b1, 16'h7E18, 9'h15A};
        rows[3] = '{2'h3, 1'b1, 16'h0F0F, 9'h023};
        do_reset();
        foreach (rows[i]) run_row(rows[i]);
        $display("test table done");
        // unselected reads must not clear; mask gates the output only
        reply = 9'h1C3;
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b1, 32'h80);
        ahb(1'b1, scir_pkg::IDX_TX_LOW, 1'b1, 32'h3C);
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b0, 32'h0);
        chk("busy in frame", 32'h1, {31'h0, d[3]});
        // a transmit byte written mid-frame must be dropped
        ahb(1'b1, scir_pkg::IDX_TX_HIGH, 1'b1, 32'hFF);
        while (serial_oe_n !== 1'b1) @(posedge hclk);
        repeat (2) @(posedge hclk);
        #1;
        chk("irq pending", 32'h1, {31'h0, int_out});
        chk("irq frame word", {16'h0, rows[3].tx[15:8], 8'h3C}, {16'h0, got});
        ahb(1'b0, scir_pkg::IDX_CTRL, 1'b0, 32'h0);
        #1;
        chk("irq after unselected read", 32'h1, {31'h0, int_out});
        ahb(1'b1, scir_pkg::IDX_TX_HIGH, 1'b0, 32'h0);
        chk("tx high kept", {24'h0, rows[3].tx[15:8]}, d);
        ahb(1'b1, scir_pkg::IDX_IRQ_STAT, 1'b0, 32'h0);
        chk("irq status", 32'h1, d);
        ahb(1'b1, scir_pkg::IDX_IRQ_MASK, 1'b1, 32'h0);
        #1;
        chk("irq masked", 32'h0, {31'h0, int_out});
        ahb(1'b1, scir_pkg::IDX_IRQ_MASK, 1'b1, 32'h1);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, int_out});
        ahb(1'b1, scir_pkg::IDX_IRQ_STAT, 1'b1, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, int_out});
        ahb(1'b1, 4'hF, 1'b0, 32'h0);
        chk("unmapped read", 32'h0, d);
        $display("test irq done");
        // reset in mid-frame must drop the link at once
        ahb(1'b1, scir_pkg::IDX_CTRL, 1'b1, 32'h83);
        ahb(1'b1, scir_pkg::IDX_TX_LOW, 1'b1, 32'h55);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b0;
        do_reset();
        give_verdict();
    end

    // whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        give_verdict();
    end
endmodule : serial_clock_irq_reset_tb
